// [src/dsrx_pkg.sv]
// Shared constants, register map and carrier types of the DS-1 receive front end.
package dsrx_pkg;

  // Timing: system clock and nominal DS-1 bit period.
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned BIT_PERIOD_PS = 647668;
  localparam logic [7:0] BIT_CYCLES = 8'(BIT_PERIOD_PS / CLK_PERIOD_PS);
  localparam logic [7:0] BIT_HALF = 8'(BIT_PERIOD_PS / CLK_PERIOD_PS / 2);

  // Loss of signal after this many empty bit periods (176).
  localparam logic [7:0] LOS_BITS = 8'hb0;

  // Phase correction shifts of the two recovery algorithms.
  localparam logic [2:0] SHIFT_NARROW = 3'h3;
  localparam logic [2:0] SHIFT_WIDE = 3'h1;

  // Register offsets.
  localparam logic [7:0] ADDR_CONFIG = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h41;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h42;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h43;
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h44;
  localparam logic [7:0] ADDR_SLICER = 8'h5d;

  // Field positions.
  localparam int CFG_WIDTH = 5;
  localparam int SLC_SQ_EN_BIT = 0;
  localparam int SLC_SQ_BIT = 7;
  localparam int IRQ_WIDTH = 4;
  localparam int IRQ_SQ = 0;
  localparam int IRQ_LOS_SET = 1;
  localparam int IRQ_LOS_CLR = 2;
  localparam int IRQ_LCV = 3;
  localparam int LST_LOS_BIT = 0;
  localparam int LST_SQ_BIT = 1;
  localparam int LST_ANALOG_BIT = 2;

  // Reset values.
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // Positions of the asynchronous inputs in the synchroniser vector.
  localparam int ASY_WIDTH = 7;
  localparam int ASY_RCLK = 0;
  localparam int ASY_PIN_POS = 1;
  localparam int ASY_PIN_NEG = 2;
  localparam int ASY_SLC_POS = 3;
  localparam int ASY_SLC_NEG = 4;
  localparam int ASY_SQUELCH = 5;
  localparam int ASY_ANALOG = 6;

  // B8ZS window length in bits.
  localparam int WIN_BITS = 8;

  typedef enum logic [1:0] {
    MODE_DUAL_RZ = 2'h0,
    MODE_DUAL_NRZ = 2'h1,
    MODE_SINGLE = 2'h3
  } dsrx_mode_type;

  typedef struct packed {
    logic algoSel;
    logic b8zsEn;
    logic fallEdge;
    logic [1:0] mode;
  } dsrx_cfg_type;

  typedef struct packed {
    logic pos;
    logic neg;
    logic viol;
  } dsrx_sym_type;

endpackage : dsrx_pkg

// [src/dsrx_dpll.sv]
// Digital phase-locked loop that regenerates the bit clock from RZ line pulses.
`timescale 1ns/1ns
`default_nettype none
module dsrx_dpll (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pulseIn,
  input wire logic algoSel,
  output logic bitStrobe
);

  logic [7:0] phase_q;
  logic [7:0] phase_d;
  logic [8:0] advSum;
  logic [7:0] lateBy;
  logic [7:0] earlyBy;
  logic [2:0] shift;

  // A pulse is expected at phase zero; the bit is closed half a period later.
  assign shift = algoSel ? dsrx_pkg::SHIFT_WIDE : dsrx_pkg::SHIFT_NARROW; // see R15
  assign lateBy = phase_q >> shift;
  assign earlyBy = (dsrx_pkg::BIT_CYCLES - phase_q) >> shift;
  assign advSum = {1'b0, phase_q} + {1'b0, earlyBy} + 9'h001;

  // The narrow step filters high-frequency jitter; the wide step follows fast jitter.
  always_comb begin
    phase_d = (phase_q == dsrx_pkg::BIT_CYCLES - 8'h01) ? 8'h00 : phase_q + 8'h01;
    if (pulseIn) begin
      if (phase_q < dsrx_pkg::BIT_HALF) begin
        phase_d = phase_q - lateBy + 8'h01; // see R08
      end else if (advSum >= {1'b0, dsrx_pkg::BIT_CYCLES}) begin
        phase_d = 8'(advSum - {1'b0, dsrx_pkg::BIT_CYCLES});
      end else begin
        phase_d = advSum[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_q <= 8'h00;
      bitStrobe <= 1'b0;
    end else begin
      phase_q <= phase_d;
      bitStrobe <= (phase_q == dsrx_pkg::BIT_HALF);
    end
  end

endmodule : dsrx_dpll
`default_nettype wire

// [src/dsrx_front_end.sv]
// DS-1 receive front end: input selection, clock recovery, B8ZS, violations, loss of signal.
`timescale 1ns/1ns
`default_nettype none

// How it works
// R01: Dual-rail pins take positive/negative, RZ or NRZ.
// R02: Dual-rail NRZ sampled on chosen input clock edge.
// R03: Single-rail takes data and violation on chosen edge.
// R04: Analog path drives sliced pulses out on pins.
// R05: Without analog supply, RZ pulses enter on pins.
// R06: Squelch blocks slicing and shows squelch status bit.
// R07: Every squelch status change may interrupt.
// R08: Phase-locked loop regenerates clock, data leaves NRZ.
// R09: Block decodes B8ZS, finds violations and signal loss.
// R10: Loss declared after 176 empty bit periods.
// R11: One line pulse clears loss of signal.
// R12: Loss and return of signal may interrupt.
// R13: AMI: every bipolar violation is a code violation.
// R14: B8ZS: only violations outside substitutions count.
// R15: Select bit picks first or second recovery algorithm.
// R16: Pattern 000VB0VB becomes eight zeros.
module dsrx_front_end (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic rxInputClock,
  input wire logic rxPosRailIn,
  output logic slicedPosOut,
  output logic slicedPosOeN,
  input wire logic rxNegRailIn,
  output logic slicedNegOut,
  output logic slicedNegOeN,
  input wire logic slicerPosIn,
  input wire logic slicerNegIn,
  input wire logic squelchIn,
  input wire logic rxAnalogSupply,
  output logic rxDataOut,
  output logic rxBitStrobe,
  output logic lcvOut,
  output logic losOut,
  output logic irqOut
);

  localparam int W = dsrx_pkg::WIN_BITS;

  // Input synchronisers; the first stage is read by the second only.
  logic [dsrx_pkg::ASY_WIDTH-1:0] asyncIn;
  logic [dsrx_pkg::ASY_WIDTH-1:0] syncA_q;
  logic [dsrx_pkg::ASY_WIDTH-1:0] syncB_q;
  logic rclkPrev_q;
  logic posPrev_q;
  logic negPrev_q;

  // Registers.
  logic [dsrx_pkg::CFG_WIDTH-1:0] cfgReg_q;
  logic [dsrx_pkg::IRQ_WIDTH-1:0] irqEn_q;
  logic [dsrx_pkg::IRQ_WIDTH-1:0] irqStat_q;
  logic [dsrx_pkg::IRQ_WIDTH-1:0] irqStat_d;
  logic [dsrx_pkg::IRQ_WIDTH-1:0] irqEvents;
  logic [dsrx_pkg::IRQ_WIDTH-1:0] irqClear;
  dsrx_pkg::dsrx_cfg_type cfg;

  // Line state.
  logic analogMode_q;
  logic squelchPrev_q;
  logic pendPos_q;
  logic pendNeg_q;
  logic lastPol_q;
  logic havePrev_q;
  logic refPol_q;
  logic haveRef_q;
  logic [W-1:0] rawPos_q;
  logic [W-1:0] rawNeg_q;
  logic [W-1:0] dat_q;
  logic [W-1:0] vio_q;
  logic [7:0] losCount_q;
  logic los_q;

  // Combinational terms.
  logic squelchActive;
  logic posLevel;
  logic negLevel;
  logic posPulse;
  logic negPulse;
  logic rclkRise;
  logic rclkFall;
  logic sampleEdge;
  logic singleMode;
  logic rzMode;
  logic dpllStrobe;
  logic symStrobe;
  logic symMark;
  logic bpv;
  logic lineActivity;
  dsrx_pkg::dsrx_sym_type symIn;
  logic [W-1:0] nextPos;
  logic [W-1:0] nextNeg;
  logic leavingMark;
  logic refPolNext;
  logic haveRefNext;
  logic [W-1:0] polP;
  logic [W-1:0] polN;
  logic [W-1:0] isZero;
  logic substMatch;
  logic losSet;
  logic losClr;
  logic selConfig;
  logic selStatus;
  logic selClear;
  logic selEnable;
  logic selLine;
  logic selSlicer;
  logic [7:0] rdMux;

  assign cfg = dsrx_pkg::dsrx_cfg_type'(cfgReg_q);

  assign asyncIn[dsrx_pkg::ASY_RCLK] = rxInputClock;
  assign asyncIn[dsrx_pkg::ASY_PIN_POS] = rxPosRailIn;
  assign asyncIn[dsrx_pkg::ASY_PIN_NEG] = rxNegRailIn;
  assign asyncIn[dsrx_pkg::ASY_SLC_POS] = slicerPosIn;
  assign asyncIn[dsrx_pkg::ASY_SLC_NEG] = slicerNegIn;
  assign asyncIn[dsrx_pkg::ASY_SQUELCH] = squelchIn;
  assign asyncIn[dsrx_pkg::ASY_ANALOG] = rxAnalogSupply;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= asyncIn;
      syncB_q <= syncA_q;
    end
  end

  // Input selection. Analog mode always feeds RZ pulses from the slicer.
  assign squelchActive = analogMode_q & syncB_q[dsrx_pkg::ASY_SQUELCH]; // see R06
  assign singleMode = ~analogMode_q && (cfg.mode == dsrx_pkg::MODE_SINGLE);
  assign rzMode = analogMode_q || (cfg.mode == dsrx_pkg::MODE_DUAL_RZ)
                  || (cfg.mode == 2'h2); // see R01
  assign posLevel = analogMode_q
                  ? (syncB_q[dsrx_pkg::ASY_SLC_POS] & ~squelchActive)
                  : syncB_q[dsrx_pkg::ASY_PIN_POS]; // see R05
  assign negLevel = analogMode_q
                  ? (syncB_q[dsrx_pkg::ASY_SLC_NEG] & ~squelchActive)
                  : syncB_q[dsrx_pkg::ASY_PIN_NEG]; // see R05
  assign posPulse = rzMode & posLevel & ~posPrev_q;
  assign negPulse = rzMode & negLevel & ~negPrev_q;

  // Edge choice on the receive input clock for NRZ and single-rail sampling.
  assign rclkRise = syncB_q[dsrx_pkg::ASY_RCLK] & ~rclkPrev_q;
  assign rclkFall = ~syncB_q[dsrx_pkg::ASY_RCLK] & rclkPrev_q;
  assign sampleEdge = cfg.fallEdge ? rclkFall : rclkRise; // see R02 see R03

  dsrx_dpll u_dpll (
    .clk(clk),
    .resetn(resetn),
    .pulseIn(posPulse | negPulse),
    .algoSel(cfg.algoSel),
    .bitStrobe(dpllStrobe)
  );

  // One symbol per bit period; a pulse landing on the strobe belongs to that bit.
  assign symStrobe = rzMode ? dpllStrobe : sampleEdge; // see R08
  assign symIn.pos = rzMode ? (pendPos_q | posPulse) : posLevel;
  assign symIn.neg = singleMode ? 1'b0 : (rzMode ? (pendNeg_q | negPulse) : negLevel);
  assign symMark = symIn.pos | symIn.neg;
  // A mark of the same polarity as the previous one, or on both rails, is a violation.
  assign bpv = (symIn.pos & symIn.neg)
             | (symMark & havePrev_q & (symIn.pos == lastPol_q)); // see R13
  assign symIn.viol = singleMode ? negLevel : bpv; // see R03

  // B8ZS window: index 0 is the oldest bit, new bits enter at the top.
  assign nextPos = {symIn.pos, rawPos_q[W-1:1]};
  assign nextNeg = {symIn.neg, rawNeg_q[W-1:1]};
  assign leavingMark = rawPos_q[0] | rawNeg_q[0];
  assign refPolNext = leavingMark ? rawPos_q[0] : refPol_q;
  assign haveRefNext = haveRef_q | leavingMark;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_win
      assign isZero[i] = ~nextPos[i] & ~nextNeg[i];
      assign polP[i] = refPolNext ? (nextPos[i] & ~nextNeg[i]) : (nextNeg[i] & ~nextPos[i]);
      assign polN[i] = refPolNext ? (nextNeg[i] & ~nextPos[i]) : (nextPos[i] & ~nextNeg[i]);
    end
  endgenerate

  // Zeros, violation, bipolar mark, zero, violation, bipolar mark.
  assign substMatch = cfg.b8zsEn & ~singleMode & haveRefNext & symStrobe
                    & isZero[0] & isZero[1] & isZero[2] & polP[3] & polN[4]
                    & isZero[5] & polN[6] & polP[7]; // see R16

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rawPos_q <= '0;
      rawNeg_q <= '0;
      dat_q <= '0;
      vio_q <= '0;
      refPol_q <= 1'b0;
      haveRef_q <= 1'b0;
    end else if (symStrobe) begin
      rawPos_q <= nextPos;
      rawNeg_q <= nextNeg;
      refPol_q <= refPolNext;
      haveRef_q <= haveRefNext;
      if (substMatch) begin
        dat_q <= '0; // see R16
        vio_q <= '0; // see R14
      end else begin
        dat_q <= {symMark, dat_q[W-1:1]};
        vio_q <= {symIn.viol, vio_q[W-1:1]}; // see R09
      end
    end
  end

  // Pending marks and polarity memory for violation checks.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pendPos_q <= 1'b0;
      pendNeg_q <= 1'b0;
      lastPol_q <= 1'b0;
      havePrev_q <= 1'b0;
    end else begin
      pendPos_q <= symStrobe ? 1'b0 : (pendPos_q | posPulse);
      pendNeg_q <= symStrobe ? 1'b0 : (pendNeg_q | negPulse);
      if (symStrobe && symMark && !singleMode) begin
        lastPol_q <= symIn.pos;
        havePrev_q <= 1'b1;
      end
    end
  end

  // Recovered NRZ output, delayed by the window length.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxDataOut <= 1'b0;
      rxBitStrobe <= 1'b0;
      lcvOut <= 1'b0;
    end else begin
      rxBitStrobe <= symStrobe;
      lcvOut <= symStrobe & vio_q[0]; // see R13 see R14
      if (symStrobe) begin
        rxDataOut <= dat_q[0]; // see R08
      end
    end
  end

  // Loss of signal. Activity wins over counting so one pulse always clears it.
  assign lineActivity = rzMode ? (posPulse | negPulse) : (sampleEdge & (posLevel | negLevel));
  assign losSet = ~lineActivity & symStrobe & ~los_q
                & (losCount_q == dsrx_pkg::LOS_BITS - 8'h01); // see R10
  assign losClr = lineActivity & los_q; // see R11

  always_ff @(posedge clk) begin
    if (!resetn) begin
      losCount_q <= 8'h00;
      los_q <= 1'b0;
    end else if (lineActivity) begin
      losCount_q <= 8'h00;
      los_q <= 1'b0; // see R11
    end else if (symStrobe && losCount_q != dsrx_pkg::LOS_BITS) begin
      losCount_q <= losCount_q + 8'h01;
      if (losSet) begin
        los_q <= 1'b1; // see R10
      end
    end
  end

  assign losOut = los_q;

  // Pin direction and slicer outputs; analog mode turns the shared pins around.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      analogMode_q <= 1'b0;
      posPrev_q <= 1'b0;
      negPrev_q <= 1'b0;
      rclkPrev_q <= 1'b0;
      squelchPrev_q <= 1'b0;
      slicedPosOut <= 1'b0;
      slicedNegOut <= 1'b0;
      slicedPosOeN <= 1'b1;
      slicedNegOeN <= 1'b1;
    end else begin
      analogMode_q <= syncB_q[dsrx_pkg::ASY_ANALOG];
      posPrev_q <= posLevel;
      negPrev_q <= negLevel;
      rclkPrev_q <= syncB_q[dsrx_pkg::ASY_RCLK];
      squelchPrev_q <= squelchActive;
      slicedPosOut <= analogMode_q & posLevel; // see R04
      slicedNegOut <= analogMode_q & negLevel; // see R04
      slicedPosOeN <= ~analogMode_q;
      slicedNegOeN <= ~analogMode_q;
    end
  end

  // Register decode.
  assign selConfig = regAddr == dsrx_pkg::ADDR_CONFIG;
  assign selStatus = regAddr == dsrx_pkg::ADDR_IRQ_STATUS;
  assign selClear = regAddr == dsrx_pkg::ADDR_IRQ_CLEAR;
  assign selEnable = regAddr == dsrx_pkg::ADDR_IRQ_ENABLE;
  assign selLine = regAddr == dsrx_pkg::ADDR_LINE_STATUS;
  assign selSlicer = regAddr == dsrx_pkg::ADDR_SLICER;

  // Interrupt events; a set in the same cycle as a clear is kept.
  assign irqEvents[dsrx_pkg::IRQ_SQ] = squelchActive ^ squelchPrev_q; // see R07
  assign irqEvents[dsrx_pkg::IRQ_LOS_SET] = losSet; // see R12
  assign irqEvents[dsrx_pkg::IRQ_LOS_CLR] = losClr; // see R12
  assign irqEvents[dsrx_pkg::IRQ_LCV] = symStrobe & vio_q[0];
  assign irqClear = (regWrite && selClear) ? regWrData[dsrx_pkg::IRQ_WIDTH-1:0] : '0;
  assign irqStat_d = (irqStat_q & ~irqClear) | irqEvents;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfgReg_q <= dsrx_pkg::CFG_RESET;
      irqEn_q <= dsrx_pkg::IRQ_RESET;
      irqStat_q <= dsrx_pkg::IRQ_RESET;
      irqOut <= 1'b0;
    end else begin
      irqStat_q <= irqStat_d;
      irqOut <= |(irqStat_d & irqEn_q);
      if (regWrite && selConfig) begin
        cfgReg_q <= regWrData[dsrx_pkg::CFG_WIDTH-1:0]; // see R15
      end
      if (regWrite && selEnable) begin
        irqEn_q <= regWrData[dsrx_pkg::IRQ_WIDTH-1:0];
      end else if (regWrite && selSlicer) begin
        irqEn_q[dsrx_pkg::IRQ_SQ] <= regWrData[dsrx_pkg::SLC_SQ_EN_BIT]; // see R07
      end
    end
  end

  // Read data stand one cycle after the strobe; unmapped and write-only read zero.
  always_comb begin
    rdMux = 8'h00;
    if (selConfig) begin
      rdMux[dsrx_pkg::CFG_WIDTH-1:0] = cfgReg_q;
    end else if (selStatus) begin
      rdMux[dsrx_pkg::IRQ_WIDTH-1:0] = irqStat_q;
    end else if (selEnable) begin
      rdMux[dsrx_pkg::IRQ_WIDTH-1:0] = irqEn_q;
    end else if (selLine) begin
      rdMux[dsrx_pkg::LST_LOS_BIT] = los_q;
      rdMux[dsrx_pkg::LST_SQ_BIT] = squelchActive;
      rdMux[dsrx_pkg::LST_ANALOG_BIT] = analogMode_q;
    end else if (selSlicer) begin
      rdMux[dsrx_pkg::SLC_SQ_EN_BIT] = irqEn_q[dsrx_pkg::IRQ_SQ];
      rdMux[dsrx_pkg::SLC_SQ_BIT] = squelchActive; // see R06
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= regRead ? rdMux : 8'h00;
    end
  end

endmodule : dsrx_front_end
`default_nettype wire

// [verif/dsrx_front_end_assertions.sv]
// Port-level checks of the DS-1 receive front end, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module dsrx_front_end_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire logic rxPosRailIn,
  input wire logic rxNegRailIn,
  input wire logic slicerPosIn,
  input wire logic slicerNegIn,
  input wire logic squelchIn,
  input wire logic rxAnalogSupply,
  input wire logic slicedPosOut,
  input wire logic slicedPosOeN,
  input wire logic slicedNegOut,
  input wire logic slicedNegOeN,
  input wire logic rxDataOut,
  input wire logic rxBitStrobe,
  input wire logic lcvOut,
  input wire logic losOut,
  input wire logic irqOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Enable bits are mirrored from bus writes, so interrupt checks need no internal probe.
  logic [3:0] irqEnable_q;
  logic [7:0] quiet_q;
  wire logic enWrite = regWrite && regAddr == dsrx_pkg::ADDR_IRQ_ENABLE;
  wire logic slcWrite = regWrite && regAddr == dsrx_pkg::ADDR_SLICER;
  wire logic lineBusy = rxPosRailIn | rxNegRailIn | slicerPosIn | slicerNegIn;
  always_ff @(posedge clk) begin
    if (!resetn) irqEnable_q <= 4'h0;
    else if (enWrite) irqEnable_q <= regWrData[3:0];
    else if (slcWrite) irqEnable_q[0] <= regWrData[0];
  end
  // The quiet count restarts on any pin activity, so it can only undercount empty bits.
  always_ff @(posedge clk) begin
    if (!resetn || lineBusy) quiet_q <= 8'h00;
    else if (rxBitStrobe && quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;
  end
  AST_OE_ANALOG: assert property (rxAnalogSupply [*5] |-> !slicedPosOeN && !slicedNegOeN)
    else $error("sliced pins not driven in analog mode");
  AST_OE_DIGITAL: assert property (!rxAnalogSupply [*5] |-> slicedPosOeN && slicedNegOeN)
    else $error("pins driven in digital mode");
  AST_SQ_BLOCK: assert property (squelchIn [*5] |-> !slicedPosOut && !slicedNegOut)
    else $error("slicing while squelched");
  AST_SQ_STATUS: assert property ((rxAnalogSupply && squelchIn) [*6] ##0
    (regRead && regAddr == dsrx_pkg::ADDR_SLICER) |=> regRdData[dsrx_pkg::SLC_SQ_BIT])
    else $error("squelch status bit low while squelched");
  AST_SQ_IRQ: assert property ($changed(squelchIn) && rxAnalogSupply &&
    irqEnable_q[dsrx_pkg::IRQ_SQ] |-> ##[2:6] irqOut)
    else $error("no interrupt on squelch change");
  AST_STROBE_PULSE: assert property (rxBitStrobe |=> !rxBitStrobe)
    else $error("bit strobe longer than one cycle");
  AST_DATA_ON_STROBE: assert property ($changed(rxDataOut) |-> rxBitStrobe)
    else $error("data changed between strobes");
  AST_LCV_ON_STROBE: assert property (lcvOut |-> rxBitStrobe)
    else $error("violation pulse off the bit strobe");
  AST_LOS_QUIET: assert property ($rose(losOut) |-> quiet_q >= 8'hae)
    else $error("loss of signal declared too early");
  AST_LOS_CLEAR: assert property (losOut && $rose(rxPosRailIn) && !rxAnalogSupply
    |-> ##[1:60] !losOut)
    else $error("loss of signal not cleared by a pulse");
  AST_LOS_IRQ: assert property ($rose(losOut) && irqEnable_q[dsrx_pkg::IRQ_LOS_SET]
    |-> ##[0:1] irqOut)
    else $error("no interrupt on loss of signal");
endmodule : dsrx_front_end_assertions
bind dsrx_front_end dsrx_front_end_assertions chk_u (
  .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .rxPosRailIn(rxPosRailIn), .rxNegRailIn(rxNegRailIn), .slicerPosIn(slicerPosIn),
  .slicerNegIn(slicerNegIn), .squelchIn(squelchIn), .rxAnalogSupply(rxAnalogSupply),
  .slicedPosOut(slicedPosOut), .slicedPosOeN(slicedPosOeN), .slicedNegOut(slicedNegOut),
  .slicedNegOeN(slicedNegOeN), .rxDataOut(rxDataOut), .rxBitStrobe(rxBitStrobe),
  .lcvOut(lcvOut), .losOut(losOut), .irqOut(irqOut)
);
`default_nettype wire

// [verif/dsrx_line_model.sv]
// Behavioural DS-1 line: RZ marks, or NRZ bits with an input clock that runs only in frames.
`timescale 1ns/1ns
`default_nettype none
module dsrx_line_model (
  input wire logic clk,
  output logic posRail,
  output logic negRail,
  output logic rxClock
);
  initial begin
    posRail = 1'b0;
    negRail = 1'b0;
    rxClock = 1'b0;
  end
  // One RZ symbol: sym[1] marks the positive rail, sym[0] the negative, for half a bit.
  task automatic sendRz(input logic [1:0] sym);
    posRail <= sym[1];
    negRail <= sym[0];
    repeat (80) @(posedge clk);
    posRail <= 1'b0;
    negRail <= 1'b0;
    repeat (81) @(posedge clk);
  endtask : sendRz
  // Each bit is valid only around the chosen edge and inverted elsewhere, so a wrong edge
  // corrupts the data instead of passing by luck.
  task automatic sendNrz(input logic [15:0] pBits, input logic [15:0] nBits, input logic fall);
    if (fall) rxClock <= 1'b1;
    repeat (10) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      posRail <= ~pBits[i];
      negRail <= ~nBits[i];
      repeat (5) @(posedge clk);
      posRail <= pBits[i];
      negRail <= nBits[i];
      repeat (5) @(posedge clk);
      rxClock <= ~rxClock;
      repeat (15) @(posedge clk);
      posRail <= ~pBits[i];
      negRail <= ~nBits[i];
      repeat (5) @(posedge clk);
      rxClock <= ~rxClock;
      repeat (10) @(posedge clk);
    end
    posRail <= 1'b0;
    negRail <= 1'b0;
    repeat (10) @(posedge clk);
    rxClock <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : sendNrz
endmodule : dsrx_line_model
`default_nettype wire

// [verif/test_ds1_receive_front_end.sv]
// Register-level and line-level tests of the DS-1 receive front end.
`timescale 1ns/1ns
`default_nettype none
module test_ds1_receive_front_end;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic slicerPosIn = 1'b0;
  logic slicerNegIn = 1'b0;
  logic squelchIn = 1'b0;
  logic rxAnalogSupply = 1'b0;
  logic [7:0] regRdData;
  logic linePos, lineNeg, lineClk;
  logic slicedPosOut, slicedPosOeN, slicedNegOut, slicedNegOeN;
  logic rxDataOut, rxBitStrobe, lcvOut, losOut, irqOut;
  int miscompares = 0;
  int checkCount = 0;
  int onesSeen = 0;
  int lcvSeen = 0;
  int waited;
  // The shared pins carry the sliced pulses whenever the design enables them.
  wire logic pinPos = slicedPosOeN ? linePos : slicedPosOut;
  wire logic pinNeg = slicedNegOeN ? lineNeg : slicedNegOut;
  dsrx_line_model lineU (.clk(clk), .posRail(linePos), .negRail(lineNeg), .rxClock(lineClk));
  dsrx_front_end dut_u (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .rxInputClock(lineClk),
    .rxPosRailIn(pinPos), .slicedPosOut(slicedPosOut), .slicedPosOeN(slicedPosOeN),
    .rxNegRailIn(pinNeg), .slicedNegOut(slicedNegOut), .slicedNegOeN(slicedNegOeN),
    .slicerPosIn(slicerPosIn), .slicerNegIn(slicerNegIn), .squelchIn(squelchIn),
    .rxAnalogSupply(rxAnalogSupply), .rxDataOut(rxDataOut), .rxBitStrobe(rxBitStrobe),
    .lcvOut(lcvOut), .losOut(losOut), .irqOut(irqOut)
  );
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rxBitStrobe === 1'b1 && rxDataOut === 1'b1) onesSeen++;
    if (rxBitStrobe === 1'b1 && lcvOut === 1'b1) lcvSeen++;
  end
  task automatic chk(input bit ok, input string msg);
    checkCount++;
    if (!ok) begin
      miscompares++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic giveVerdict;
    $display("Checks %0d, mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : giveVerdict
  task automatic regWr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    regAddr <= addr;
    regWrData <= data;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : regWr
  task automatic regRd(input logic [7:0] addr, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge clk);
    regAddr <= addr;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    chk((regRdData & mask) === exp, $sformatf("read %h gave %h", addr, regRdData));
  endtask : regRd
  // Runs a stream in one configuration, flushes the decode window after an RZ stream only, and counts what came out.
  task automatic lineRun(input logic [7:0] cfg, input logic [31:0] seq, input int ones,
    input int lcvs);
    int ones0;
    int lcvs0;
    regWr(dsrx_pkg::ADDR_CONFIG, cfg);
    ones0 = onesSeen;
    lcvs0 = lcvSeen;
    if (cfg[1:0] == 2'h0) begin
      for (int i = 15; i >= 0; i--) lineU.sendRz(seq[2*i +: 2]);
      repeat (10) lineU.sendRz(2'b00);
    end else begin
      lineU.sendNrz(seq[31:16], seq[15:0], cfg[2]);
    end
    chk(onesSeen - ones0 == ones, $sformatf("config %h: %0d ones", cfg, onesSeen - ones0));
    chk(lcvSeen - lcvs0 == lcvs, $sformatf("config %h: %0d violations", cfg, lcvSeen - lcvs0));
  endtask : lineRun
  task automatic slicePulse(input logic pos, input logic expOut);
    slicerPosIn <= pos;
    slicerNegIn <= ~pos;
    repeat (10) @(posedge clk);
    #1;
    chk(slicedPosOut === (pos & expOut) && slicedNegOut === (~pos & expOut), "sliced pulse");
    @(posedge clk);
    slicerPosIn <= 1'b0;
    slicerNegIn <= 1'b0;
    repeat (150) @(posedge clk);
  endtask : slicePulse
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    regRd(dsrx_pkg::ADDR_CONFIG, 8'h00, 8'hff);
    regRd(dsrx_pkg::ADDR_IRQ_STATUS, 8'h00, 8'hff);
    regRd(dsrx_pkg::ADDR_IRQ_ENABLE, 8'h00, 8'hff);
    regRd(dsrx_pkg::ADDR_LINE_STATUS, 8'h00, 8'hff);
    regRd(dsrx_pkg::ADDR_IRQ_CLEAR, 8'h00, 8'hff);
    regWr(8'h77, 8'hff);
    regRd(8'h77, 8'h00, 8'hff);
    regWr(dsrx_pkg::ADDR_CONFIG, 8'h1f);
    regRd(dsrx_pkg::ADDR_CONFIG, 8'h1f, 8'hff);
    regWr(dsrx_pkg::ADDR_CONFIG, 8'h00);
    regWr(dsrx_pkg::ADDR_IRQ_ENABLE, 8'h06);
    waited = 0;
    while (losOut !== 1'b1 && waited < 30000) begin
      @(posedge clk);
      waited++;
    end
    chk(waited >= 174 * 161 && waited <= 178 * 161, "loss of signal timing");
    if (losOut !== 1'b1) giveVerdict();
    regRd(dsrx_pkg::ADDR_LINE_STATUS, 8'h01, 8'h07);
    regRd(dsrx_pkg::ADDR_IRQ_STATUS, 8'h02, 8'h0f);
    chk(irqOut === 1'b1, "no interrupt on loss");
    regWr(dsrx_pkg::ADDR_IRQ_ENABLE, 8'h04);
    repeat (2) @(posedge clk);
    #1;
    chk(irqOut === 1'b0, "masked loss still interrupts");
    lineU.sendRz(2'b10);
    chk(losOut === 1'b0, "loss not cleared by one mark");
    chk(irqOut === 1'b1, "no interrupt on signal return");
    regRd(dsrx_pkg::ADDR_IRQ_STATUS, 8'h06, 8'h0f);
    regWr(dsrx_pkg::ADDR_IRQ_CLEAR, 8'h0f);
    regWr(dsrx_pkg::ADDR_IRQ_ENABLE, 8'h00);
    regRd(dsrx_pkg::ADDR_IRQ_STATUS, 8'h00, 8'h0f);
    // The returning mark is still in the decode window; flush it before counting.
    repeat (10) lineU.sendRz(2'b00);
    lineRun(8'h00, 32'h61860661, 11, 0);
    lineRun(8'h00, 32'h22110000, 4, 2);
    regRd(dsrx_pkg::ADDR_IRQ_STATUS, 8'h08, 8'h08);
    lineRun(8'h08, 32'h80919000, 2, 0);
    lineRun(8'h00, 32'h80919000, 6, 2);
    lineRun(8'h10, 32'h92490992, 11, 0);
    lineRun(8'h01, 32'h5200a400, 6, 0);
    lineRun(8'h05, 32'h5200a400, 6, 0);
    lineRun(8'h07, 32'hc5002100, 4, 2);
    rxAnalogSupply <= 1'b1;
    repeat (8) @(posedge clk);
    chk(slicedPosOeN === 1'b0 && slicedNegOeN === 1'b0, "pins not outputs");
    regRd(dsrx_pkg::ADDR_LINE_STATUS, 8'h04, 8'h04);
    slicePulse(1'b1, 1'b1);
    slicePulse(1'b0, 1'b1);
    regWr(dsrx_pkg::ADDR_SLICER, 8'h01);
    regRd(dsrx_pkg::ADDR_IRQ_ENABLE, 8'h01, 8'h0f);
    regWr(dsrx_pkg::ADDR_IRQ_CLEAR, 8'h0f);
    squelchIn <= 1'b1;
    repeat (10) @(posedge clk);
    regRd(dsrx_pkg::ADDR_SLICER, 8'h81, 8'h81);
    chk(irqOut === 1'b1, "no interrupt on squelch");
    slicePulse(1'b1, 1'b0);
    regWr(dsrx_pkg::ADDR_IRQ_CLEAR, 8'h01);
    @(posedge clk);
    #1;
    chk(irqOut === 1'b0, "squelch interrupt not cleared");
    squelchIn <= 1'b0;
    repeat (10) @(posedge clk);
    chk(irqOut === 1'b1, "no interrupt on squelch release");
    regRd(dsrx_pkg::ADDR_SLICER, 8'h01, 8'h81);
    rxAnalogSupply <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(slicedPosOeN === 1'b1 && slicedNegOeN === 1'b1, "pins still driven");
    giveVerdict();
  end
endmodule : test_ds1_receive_front_end
`default_nettype wire
